// [verilog/cap_map.vh]
/*
 Register offsets, field positions, reset values and constants of the
 addressing and pointer block. Assumes 8-bit special register space.
*/
`ifndef CAP_MAP_VH
`define CAP_MAP_VH

// Register offsets
`define CAP_DP0_LOW 8'h82
`define CAP_DP0_HIGH 8'h83
`define CAP_DP1_LOW 8'h84
`define CAP_DP1_HIGH 8'h85
`define CAP_PTR_CHOICE 8'h86
`define CAP_FLASH_WAIT 8'h92
`define CAP_DP0_TOP 8'h93
`define CAP_DP1_TOP 8'h95
`define CAP_ADDR_MODE 8'h9d
`define CAP_RAM_RELOC 8'hc6
`define CAP_MOVX_PAGE 8'hda
`define CAP_MOVX_TOP 8'hea

// Reset values
`define CAP_RST_BYTE 8'h00
`define CAP_RST_WAIT 8'h07

// Writable bit masks
`define CAP_MASK_WAIT 8'h0f
`define CAP_MASK_CHOICE 8'he1
`define CAP_MASK_MODE 8'h2b

// Pointer choice fields
`define CAP_CH_SEL 0
`define CAP_CH_TOGGLE 5
`define CAP_CH_DIR0 6
`define CAP_CH_DIR1 7

// Addressing mode fields
`define CAP_AM_LOW 0
`define CAP_AM_HIGH 1
`define CAP_AM_STACK 2
`define CAP_AM_PAGE 3
`define CAP_AM_VEC 5

// Vector bases and memory sizes
`define CAP_VEC_NORMAL 16'h0000
`define CAP_VEC_RELOC 16'hb000
`define CAP_DATA_MEM_BYTES 32'h0000_0800
`define CAP_WIDE_LIMIT 32'h0001_0000

`endif

// [verilog/cap_core.v]
/*
 Address generation and memory timing support for a single-cycle
 8051-style core: flash wait states, addressing mode control, the
 24-bit data memory address for both indirect forms, and two data
 pointers with step direction and automatic toggle.
 Assumes the core, the timed-access unit and flash control run on
 i_clock; every strobe input is one cycle long and synchronous.
*/
// Added by the designer: the strobed register port.
// How it works
// - Each flash read stalls for as many cycles as the wait field.
// - The wait field resets to seven cycles.
// - Relocation register is stored and read back, has no effect.
// - Relocation and mode writes only land while timed access is open.
// - Compatible mode uses 16-bit program addresses, extended uses 20.
// - Mode bits 00 give compatible mode, upper bit set gives extended.
// - Read-only stack flag shows internal or 16-bit concatenated stack.
// - Relocation bit moves interrupt vectors to the B000 region.
// - Indirect form takes bits 15..8 from port latch or page register.
// - Indirect form takes bits 23..16 from its own top register.
// - Pointer form uses the selected pointer with its own top byte.
// - Choice bit picks second pointer when set; reads current choice.
// - Direction bits turn the increment into decrement per pointer.
// - Auto toggle flips the choice after each pointer instruction.
// - Compatible mode steps 16 bits; extended steps all 24 bits.
// - Top byte is ignored when data memory is below 64 KB.
// - Extended stack address is stack high byte over stack low byte.
// - Second pointer has its own top byte behaving like the first.
`include "cap_map.vh"

module cap_core #(
  parameter [31:0] DATA_MEM_BYTES = `CAP_DATA_MEM_BYTES
) (
  input wire i_clock,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_ta_open,
  input wire i_flash_rd,
  output reg o_flash_stall,
  input wire [19:0] i_pc,
  output reg [19:0] o_prog_addr,
  output reg o_wide_prog,
  output reg [15:0] o_vector_base,
  input wire [7:0] i_stack_ptr_low,
  input wire [7:0] i_stack_ptr_high,
  output reg [15:0] o_stack_addr,
  output reg o_stack_mode_flag,
  input wire i_movx_ri,
  input wire [7:0] i_ri_low,
  input wire [7:0] i_port2_latch,
  output reg [23:0] o_external_data_ram_addr,
  input wire i_first_data_pointer_step,
  input wire i_first_data_pointer_used
);

  // Registers
  reg [7:0] dp0_low_q;
  reg [7:0] dp0_high_q;
  reg [7:0] dp0_top_q;
  reg [7:0] dp1_low_q;
  reg [7:0] dp1_high_q;
  reg [7:0] dp1_top_q;
  reg [7:0] choice_q;
  reg [7:0] wait_q;
  reg [7:0] mode_q;
  reg [7:0] reloc_q;
  reg [7:0] page_q;
  reg [7:0] top_q;
  reg [3:0] wait_cnt_q;

  // Decoded state
  wire ext_mode;
  wire sel;
  wire dir_now;
  wire wide_mem;
  wire [23:0] ptr0;
  wire [23:0] ptr1;
  wire [23:0] ptr_sel;
  wire [23:0] ptr_next;
  wire [7:0] mode_rd;
  reg [7:0] rd_d;

  // Write strobe for one register offset
  function hit;
    input [7:0] a;
    input [7:0] off;
    input w;
    begin
      hit = w && (a == off);
    end
  endfunction

  // One pointer step, 16 or 24 bits wide
  function [23:0] step_ptr;
    input [23:0] v;
    input dn;
    input ext;
    reg [23:0] full;
    reg [15:0] low;
    begin
      full = dn ? v - 24'h00_0001 : v + 24'h00_0001;
      low = dn ? v[15:0] - 16'h0001 : v[15:0] + 16'h0001;
      step_ptr = ext ? full : {v[23:16], low};
    end
  endfunction

  assign ext_mode = mode_q[`CAP_AM_HIGH];
  assign sel = choice_q[`CAP_CH_SEL];
  assign ptr0 = {dp0_top_q, dp0_high_q, dp0_low_q};
  assign ptr1 = {dp1_top_q, dp1_high_q, dp1_low_q};
  assign ptr_sel = sel ? ptr1 : ptr0;
  // Direction bit of the pointer in force
  assign dir_now = sel ? choice_q[`CAP_CH_DIR1] :
                   choice_q[`CAP_CH_DIR0];
  assign ptr_next = step_ptr(ptr_sel, dir_now, ext_mode);
  assign wide_mem = (DATA_MEM_BYTES >= `CAP_WIDE_LIMIT);
  // Stack flag is live, not stored
  assign mode_rd = {2'b00, mode_q[`CAP_AM_VEC], 1'b0,
                    mode_q[`CAP_AM_PAGE], ext_mode,
                    mode_q[`CAP_AM_HIGH:`CAP_AM_LOW]};

  // First pointer bytes: steps, then writes that win
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dp0_low_q <= `CAP_RST_BYTE;
      dp0_high_q <= `CAP_RST_BYTE;
      dp0_top_q <= `CAP_RST_BYTE;
    end else begin
      if (i_first_data_pointer_step && !sel) begin
        dp0_low_q <= ptr_next[7:0];
        dp0_high_q <= ptr_next[15:8];
        dp0_top_q <= ptr_next[23:16];
      end
      if (hit(i_addr, `CAP_DP0_LOW, i_wr)) begin
        dp0_low_q <= i_wdata;
      end
      if (hit(i_addr, `CAP_DP0_HIGH, i_wr)) begin
        dp0_high_q <= i_wdata;
      end
      if (hit(i_addr, `CAP_DP0_TOP, i_wr)) begin
        dp0_top_q <= i_wdata;
      end
    end
  end

  // Second pointer bytes with their own top byte
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dp1_low_q <= `CAP_RST_BYTE;
      dp1_high_q <= `CAP_RST_BYTE;
      dp1_top_q <= `CAP_RST_BYTE;
    end else begin
      if (i_first_data_pointer_step && sel) begin
        dp1_low_q <= ptr_next[7:0];
        dp1_high_q <= ptr_next[15:8];
        dp1_top_q <= ptr_next[23:16];
      end
      if (hit(i_addr, `CAP_DP1_LOW, i_wr)) begin
        dp1_low_q <= i_wdata;
      end
      if (hit(i_addr, `CAP_DP1_HIGH, i_wr)) begin
        dp1_high_q <= i_wdata;
      end
      if (hit(i_addr, `CAP_DP1_TOP, i_wr)) begin
        dp1_top_q <= i_wdata;
      end
    end
  end

  // Pointer choice, direction and auto toggle
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      choice_q <= `CAP_RST_BYTE;
    end else if (hit(i_addr, `CAP_PTR_CHOICE, i_wr)) begin
      choice_q <= i_wdata & `CAP_MASK_CHOICE;
    end else if (i_first_data_pointer_used && choice_q[`CAP_CH_TOGGLE]) begin
      choice_q[`CAP_CH_SEL] <= ~sel;
    end
  end

  // Wait field and the two timed-access registers
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q <= `CAP_RST_WAIT;
      mode_q <= `CAP_RST_BYTE;
      reloc_q <= `CAP_RST_BYTE;
    end else begin
      if (hit(i_addr, `CAP_FLASH_WAIT, i_wr)) begin
        wait_q <= i_wdata & `CAP_MASK_WAIT;
      end
      if (hit(i_addr, `CAP_ADDR_MODE, i_wr) && i_ta_open) begin
        // Stack flag bit is not stored
        mode_q <= i_wdata & `CAP_MASK_MODE;
      end
      if (hit(i_addr, `CAP_RAM_RELOC, i_wr) && i_ta_open) begin
        reloc_q <= i_wdata;
      end
    end
  end

  // Indirect page and top registers
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      page_q <= `CAP_RST_BYTE;
      top_q <= `CAP_RST_BYTE;
    end else begin
      if (hit(i_addr, `CAP_MOVX_PAGE, i_wr)) begin
        page_q <= i_wdata;
      end
      if (hit(i_addr, `CAP_MOVX_TOP, i_wr)) begin
        top_q <= i_wdata;
      end
    end
  end

  // Flash wait counter; stall stands wait_q cycles after the request
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_cnt_q <= 4'h0;
      o_flash_stall <= 1'b0;
    end else if (i_flash_rd) begin
      wait_cnt_q <= wait_q[3:0];
      o_flash_stall <= (wait_q[3:0] != 4'h0);
    end else if (wait_cnt_q != 4'h0) begin
      wait_cnt_q <= wait_cnt_q - 4'h1;
      o_flash_stall <= (wait_cnt_q > 4'h1);
    end else begin
      o_flash_stall <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    rd_d = 8'h00;
    case (i_addr)
      `CAP_DP0_LOW: rd_d = dp0_low_q;
      `CAP_DP0_HIGH: rd_d = dp0_high_q;
      `CAP_DP1_LOW: rd_d = dp1_low_q;
      `CAP_DP1_HIGH: rd_d = dp1_high_q;
      `CAP_PTR_CHOICE: rd_d = choice_q;
      `CAP_FLASH_WAIT: rd_d = wait_q;
      `CAP_DP0_TOP: rd_d = dp0_top_q;
      `CAP_DP1_TOP: rd_d = dp1_top_q;
      `CAP_ADDR_MODE: rd_d = mode_rd;
      `CAP_RAM_RELOC: rd_d = reloc_q;
      `CAP_MOVX_PAGE: rd_d = page_q;
      `CAP_MOVX_TOP: rd_d = top_q;
      default: rd_d = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rd_d;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // Program address width, vector base and stack address
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prog_addr <= 20'h0_0000;
      o_wide_prog <= 1'b0;
      o_vector_base <= `CAP_VEC_NORMAL;
      o_stack_addr <= 16'h0000;
      o_stack_mode_flag <= 1'b0;
    end else begin
      o_wide_prog <= ext_mode;
      o_prog_addr <= ext_mode ? i_pc :
                     {4'h0, i_pc[15:0]};
      o_vector_base <= mode_q[`CAP_AM_VEC] ? `CAP_VEC_RELOC :
                       `CAP_VEC_NORMAL;
      o_stack_mode_flag <= ext_mode;
      o_stack_addr <= ext_mode ?
                      {i_stack_ptr_high, i_stack_ptr_low} :
                      {8'h00, i_stack_ptr_low};
    end
  end

  // Data memory address for the two indirect forms
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_external_data_ram_addr <= 24'h00_0000;
    end else if (i_movx_ri) begin
      o_external_data_ram_addr[23:16] <= top_q;
      o_external_data_ram_addr[15:8] <= mode_q[`CAP_AM_PAGE] ? page_q :
                           i_port2_latch;
      o_external_data_ram_addr[7:0] <= i_ri_low;
    end else begin
      o_external_data_ram_addr[23:16] <= wide_mem ? ptr_sel[23:16] :
                            8'h00;
      o_external_data_ram_addr[15:0] <= ptr_sel[15:0];
    end
  end

endmodule // cap_core

// [verif/cap_checker.sv]
/* Port-level assertions for cap_core, using shadow copies of registers.
 Assumes one clock, strobes sampled on the rising edge. */
`include "cap_map.vh"
module cap_checker (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_ta_open,
  input wire logic i_flash_rd,
  input wire logic o_flash_stall,
  input wire logic [19:0] i_pc,
  input wire logic [19:0] o_prog_addr,
  input wire logic o_wide_prog,
  input wire logic [15:0] o_vector_base,
  input wire logic [7:0] i_stack_ptr_low,
  input wire logic [7:0] i_stack_ptr_high,
  input wire logic [15:0] o_stack_addr,
  input wire logic o_stack_mode_flag,
  input wire logic i_movx_ri,
  input wire logic [7:0] i_ri_low,
  input wire logic [7:0] i_port2_latch,
  input wire logic [23:0] o_external_data_ram_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  logic [3:0] rem_q;
  logic [7:0] mode_q;
  logic [7:0] page_q;
  logic [7:0] top_q;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Shadow registers and remaining stall count
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q <= 4'h7;
      rem_q <= 4'h0;
      mode_q <= 8'h00;
      page_q <= 8'h00;
      top_q <= 8'h00;
    end else begin
      rem_q <= i_flash_rd ? wait_q : (rem_q == 4'h0 ? rem_q : rem_q - 4'h1);
      if (i_wr && i_addr == `CAP_FLASH_WAIT) wait_q <= i_wdata[3:0];
      if (i_wr && i_ta_open && i_addr == `CAP_ADDR_MODE) mode_q <= i_wdata;
      if (i_wr && i_addr == `CAP_MOVX_PAGE) page_q <= i_wdata;
      if (i_wr && i_addr == `CAP_MOVX_TOP) top_q <= i_wdata;
    end
  end
  // Write then read of the wait field
  sequence s_wait_wr_rd;
    i_wr && i_addr == `CAP_FLASH_WAIT ##1 i_rd && i_addr == `CAP_FLASH_WAIT;
  endsequence
  a_stall_length: assert property (o_flash_stall == (rem_q != 4'h0))
    else $error("stall length wrong");
  a_wait_readback: assert property (s_wait_wr_rd |=>
    o_rdata == ($past(i_wdata, 2) & 8'h0f)) else $error("wait readback");
  a_vector_base: assert property ($past(i_rst_n) |-> o_vector_base ==
    ($past(mode_q[5]) ? `CAP_VEC_RELOC : `CAP_VEC_NORMAL))
    else $error("vector base wrong");
  a_wide_mode: assert property ($past(i_rst_n) |->
    o_wide_prog == $past(mode_q[1])) else $error("mode select wrong");
  a_stack_flag: assert property ($past(i_rst_n) |->
    o_stack_mode_flag == $past(mode_q[1])) else $error("stack flag wrong");
  a_prog_width: assert property ($past(i_rst_n) |-> o_prog_addr ==
    ($past(mode_q[1]) ? $past(i_pc) : ($past(i_pc) & 20'h0_ffff)))
    else $error("program address wrong");
  a_stack_addr: assert property ($past(i_rst_n) |-> o_stack_addr ==
    {($past(mode_q[1]) ? $past(i_stack_ptr_high) : 8'h00),
    $past(i_stack_ptr_low)}) else $error("stack address wrong");
  a_indirect_addr: assert property ($past(i_rst_n) && $past(i_movx_ri) |->
    o_external_data_ram_addr == {$past(top_q), ($past(mode_q[3]) ? $past(page_q) :
    $past(i_port2_latch)), $past(i_ri_low)}) else $error("indirect address");
endmodule // cap_checker
bind cap_core cap_checker u_chk (.i_clock, .i_rst_n, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_ta_open, .i_flash_rd, .o_flash_stall, .i_pc,
  .o_prog_addr, .o_wide_prog, .o_vector_base, .i_stack_ptr_low,
  .i_stack_ptr_high, .o_stack_addr, .o_stack_mode_flag, .i_movx_ri,
  .i_ri_low, .i_port2_latch, .o_external_data_ram_addr);

// [verif/cap_cpu_model.sv]
/* Core-side model: issues a flash read and counts the stall cycles.
 Assumes the stall output is registered on the same clock. */
module cap_cpu_model (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic i_stall,
  output logic o_flash_rd,
  output logic [4:0] o_count,
  output logic o_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  // One-cycle read pulse, then count until the stall drops
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flash_rd <= 1'b0;
      o_count <= 5'h00;
      o_busy <= 1'b0;
    end else begin
      o_flash_rd <= i_go;
      if (i_go) begin
        o_busy <= 1'b1;
        o_count <= 5'h00;
      end else if (o_busy && !o_flash_rd) begin
        if (i_stall) o_count <= o_count + 5'h01;
        else o_busy <= 1'b0;
      end
    end
  end
endmodule // cap_cpu_model

// [verif/cap_core_bench.sv]
/* Self-checking bench for cap_core with a core-side flash model.
 Assumes a 125 MHz clock and register reads one cycle late. */
`include "cap_map.vh"
module cap_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0, i_rd = 1'b0, i_ta_open = 1'b0, go = 1'b0;
  logic i_movx_ri = 1'b0, i_first_data_pointer_step = 1'b0, i_first_data_pointer_used = 1'b0;
  logic [19:0] i_pc = 20'h5_1234;
  logic [7:0] i_ri_low = 8'h34;
  logic [7:0] i_port2_latch = 8'h12;
  wire [7:0] o_rdata;
  wire [23:0] o_external_data_ram_addr;
  wire [4:0] cnt;
  wire i_flash_rd, o_flash_stall, busy;
  int failures = 0;
  int tests_run = 0;
  localparam logic [7:0] REGS [13] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86,
    8'h92, 8'h93, 8'h95, 8'h9d, 8'hc6, 8'hda, 8'hea, 8'h90};
  localparam logic [3:0] WAITS [4] = '{4'h0, 4'h1, 4'h2, 4'hf};
  always #4 i_clock = ~i_clock;
  // 64 KB data memory so the pointer top byte is live
  cap_core #(.DATA_MEM_BYTES(32'h0001_0000)) dut (.i_clock, .i_rst_n,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_ta_open, .i_flash_rd,
    .o_flash_stall, .i_pc, .o_prog_addr(), .o_wide_prog(),
    .o_vector_base(), .i_stack_ptr_low(8'hbc), .i_stack_ptr_high(8'h9a),
    .o_stack_addr(), .o_stack_mode_flag(), .i_movx_ri, .i_ri_low,
    .i_port2_latch, .o_external_data_ram_addr, .i_first_data_pointer_step, .i_first_data_pointer_used);
  cap_cpu_model cpu (.i_clock, .i_rst_n, .i_go(go), .i_stall(o_flash_stall),
    .o_flash_rd(i_flash_rd), .o_count(cnt), .o_busy(busy));
  task chk(input string nm, input logic [23:0] seen, input logic [23:0] e);
    tests_run++;
    if (seen !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task test_done;
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic ta);
    i_addr <= a;
    i_wdata <= d;
    i_ta_open <= ta;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    i_ta_open <= 1'b0;
    @(posedge i_clock);
  endtask
  task rd(input logic [7:0] a, input logic [23:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk("rdata", {16'h0000, o_rdata}, e);
    @(posedge i_clock);
  endtask
  task xchk(input logic [23:0] e);
    repeat (2) @(posedge i_clock);
    #1 chk("external_data_ram", o_external_data_ram_addr, e);
    @(posedge i_clock);
  endtask
  task pulse(input logic used);
    i_first_data_pointer_used <= used;
    i_first_data_pointer_step <= !used;
    @(posedge i_clock);
    i_first_data_pointer_used <= 1'b0;
    i_first_data_pointer_step <= 1'b0;
  endtask
  task flash(input logic [4:0] e);
    int k;
    go <= 1'b1;
    @(posedge i_clock);
    go <= 1'b0;
    #1;
    for (k = 0; k < 40 && busy !== 1'b0; k++) begin
      @(posedge i_clock);
      #1;
    end
    if (k == 40) begin
      failures++;
      test_done();
    end
    chk("stall", {19'h0_0000, cnt}, e);
    @(posedge i_clock);
  endtask
  // Reset values, unmapped place last, then wait-state counts
  task t_reset_wait;
    for (int i = 0; i < 13; i++)
      rd(REGS[i], REGS[i] == `CAP_FLASH_WAIT ? 24'h00_0007 : 24'h00_0000);
    flash(5'h07);
    for (int i = 0; i < 4; i++) begin
      i_addr <= `CAP_FLASH_WAIT;
      i_wdata <= {4'hf, WAITS[i]};
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 chk("wait", {16'h0000, o_rdata}, {20'h0_0000, WAITS[i]});
      @(posedge i_clock);
      flash({1'b0, WAITS[i]});
    end
  endtask
  // Protected writes, mode patterns, indirect addressing
  task t_mode;
    wr(`CAP_ADDR_MODE, 8'h2b, 1'b0);
    rd(`CAP_ADDR_MODE, 24'h00_0000);
    wr(`CAP_RAM_RELOC, 8'h55, 1'b0);
    rd(`CAP_RAM_RELOC, 24'h00_0000);
    wr(`CAP_RAM_RELOC, 8'h55, 1'b1);
    rd(`CAP_RAM_RELOC, 24'h00_0055);
    wr(`CAP_RAM_RELOC, 8'h00, 1'b1);
    for (int m = 0; m < 4; m++) begin
      wr(`CAP_ADDR_MODE, {6'h3f, m[1:0]}, 1'b1);
      rd(`CAP_ADDR_MODE, {21'h00_0005, m[1], m[1:0]});
    end
    i_movx_ri <= 1'b1;
    wr(`CAP_MOVX_PAGE, 8'h56, 1'b0);
    wr(`CAP_MOVX_TOP, 8'h78, 1'b0);
    xchk(24'h78_5634);
    wr(`CAP_ADDR_MODE, 8'h00, 1'b1);
    xchk(24'h78_1234);
    i_movx_ri <= 1'b0;
  endtask
  // Pointer selection, stepping, direction and toggle
  task t_ptr;
    wr(`CAP_DP0_TOP, 8'h01, 1'b0);
    wr(`CAP_DP0_HIGH, 8'hff, 1'b0);
    wr(`CAP_DP0_LOW, 8'hff, 1'b0);
    wr(`CAP_DP1_TOP, 8'h02, 1'b0);
    xchk(24'h01_ffff);
    pulse(1'b0);
    xchk(24'h01_0000);
    wr(`CAP_PTR_CHOICE, 8'h40, 1'b0);
    pulse(1'b0);
    xchk(24'h01_ffff);
    wr(`CAP_PTR_CHOICE, 8'h81, 1'b0);
    xchk(24'h02_0000);
    pulse(1'b0);
    xchk(24'h02_ffff);
    wr(`CAP_ADDR_MODE, 8'h02, 1'b1);
    wr(`CAP_PTR_CHOICE, 8'h01, 1'b0);
    pulse(1'b0);
    xchk(24'h03_0000);
    wr(`CAP_PTR_CHOICE, 8'h21, 1'b0);
    pulse(1'b1);
    rd(`CAP_PTR_CHOICE, 24'h00_0020);
    xchk(24'h01_ffff);
  endtask
  // Reset for five cycles, then the scenarios
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    t_reset_wait();
    t_mode();
    t_ptr();
    test_done();
  end
endmodule // cap_core_bench
